// ---- asc_pkg.sv ----
// Package: register map, fields, reset values and timing counts for sync and autocal control
package asc_pkg;
  // ========================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DIV = 8'h08;
  localparam logic [7:0] OFF_RATE = 8'h0c;
  localparam logic [7:0] OFF_SRC = 8'h10;
  localparam logic [7:0] OFF_CALRES = 8'h14;
  // ========================================
  // Control word bit positions
  localparam int B_SYNC = 0;
  localparam int B_CAL = 1;
  localparam int B_CLK_INIT = 2;
  localparam int B_SYNC_INIT = 3;
  localparam int B_EXT_SYNC = 4;
  localparam int B_RAW_GEN = 5;
  localparam int B_FLUSH = 6;
  localparam int B_FAST = 7;
  localparam int B_AC = 8;
  localparam int B_IRQ_FLAG = 9;
  localparam int B_IRQ_SEL = 10;
  localparam int B_IRQ_EMU = 13;
  localparam int B_GRP_EN = 14;
  // ========================================
  // Status word bit positions
  localparam int S_READY = 0;
  localparam int S_CAL_PASS = 1;
  localparam int S_BUSY = 2;
  // ========================================
  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_c000;
  localparam logic [8:0] RST_DIV = 9'h005;
  localparam logic [23:0] RST_RATE = 24'h03_0032;
  localparam logic [3:0] RST_SRC = 4'h0;
  // ========================================
  // Clock source codes
  localparam logic [3:0] SRC_EXT = 4'h4;
  localparam logic [3:0] SRC_DIRECT = 4'h5;
  // ========================================
  // Interrupt selections
  localparam logic [2:0] IRQ_INIT = 3'h0;
  localparam logic [2:0] IRQ_CAL = 3'h1;
  localparam logic [2:0] IRQ_READY = 3'h2;
  // ========================================
  // Timing: sync and flush lengths in sample intervals of SI_FAST or SI_SLOW converter clocks, calibration and settle times in seconds
  localparam int SYNC_INTERVALS = 140;
  localparam int FLUSH_INTERVALS = 5;
  localparam int FAST_PERIODS = 140;
  localparam int SI_FAST = 256;
  localparam int SI_SLOW = 512;
  localparam int CAL_BASE_S = 1;
  localparam int CAL_MAX_S = 45;
  localparam int CLK_HZ = 25_000_000;
  localparam int CAL_BASE_CYC = CAL_BASE_S * CLK_HZ;
  localparam int AC_SETTLE_S = 5;
  localparam int AC_SETTLE_CYC = AC_SETTLE_S * CLK_HZ;
  localparam int CH_COUNT = 12;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SYNC = 3'b001,
    ST_CAL = 3'b011,
    ST_SETTLE = 3'b010,
    ST_FLUSH = 3'b110
  } asc_state_t;
endpackage

// ---- asc_div.sv ----
// Module: programmable divider producing a one-cycle tick and a half-rate square wave
`timescale 1ns/10ps
module asc_div (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic src_tick,
  input wire logic [8:0] ratio,
  output logic tick,
  output logic wave
);
  typedef struct packed {
    logic [8:0] cnt;
    logic wave;
    logic tick;
  } asc_div_t;
  asc_div_t st_ff;
  asc_div_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (src_tick) begin
      // A ratio of zero acts as one so the output never stalls
      if (st_ff.cnt + 9'h001 >= ratio) begin
        nxt_st.cnt = 9'h000;
        nxt_st.tick = 1'b1;
        nxt_st.wave = ~st_ff.wave;
      end else begin
        nxt_st.cnt = st_ff.cnt + 9'h001;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick = st_ff.tick;
  assign wave = st_ff.wave;
endmodule

// ---- asc_cal_mem.sv ----
// Module: per-channel offset and gain correction store with registered read
`timescale 1ns/10ps
module asc_cal_mem (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_ch,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] rd_ch,
  output logic [31:0] rd_data
);
  import asc_pkg::*;
  typedef struct packed {
    logic [CH_COUNT-1:0][31:0] corr;
    logic [31:0] rd;
  } asc_mem_t;
  asc_mem_t st_ff;
  asc_mem_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (wr_en && wr_ch < 4'(CH_COUNT)) begin
      nxt_st.corr[wr_ch] = wr_data;
    end
    nxt_st.rd = (rd_ch < 4'(CH_COUNT)) ? st_ff.corr[rd_ch] : 32'h0000_0000;
  end
  // Corrections live until bus reset or until a calibration writes the same channel
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rd_data = st_ff.rd;
endmodule

// ---- asc_ctrl.sv ----
// Module: converter sync, multiboard clock/sync roles, buffer clear, autocal and interrupt gating
`timescale 1ns/10ps
module asc_ctrl #(
  parameter int CAL_BASE = asc_pkg::CAL_BASE_CYC,
  parameter int AC_SETTLE = asc_pkg::AC_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gen_clk_tick,
  input wire logic ext_clk_in,
  output logic ext_clk_out,
  output logic ext_clk_oe_n,
  input wire logic ext_sync_in,
  output logic ext_sync_out,
  output logic ext_sync_oe_n,
  output logic adc_clk_tick,
  output logic adc_reset,
  output logic buf_reset,
  output logic buf_run,
  output logic ac_coupling,
  input wire logic [asc_pkg::CH_COUNT-1:0] cal_ch_ok,
  input wire logic cal_corr_valid,
  input wire logic [3:0] cal_corr_ch,
  input wire logic [31:0] cal_corr_data,
  output logic host_irq
);
  import asc_pkg::*;
  localparam int SYNC_FAST = SYNC_INTERVALS * SI_FAST;
  localparam int SYNC_SLOW = SYNC_INTERVALS * SI_SLOW;
  localparam int FLUSH_FAST = FLUSH_INTERVALS * SI_FAST;
  localparam int FLUSH_SLOW = FLUSH_INTERVALS * SI_SLOW;
  localparam int CAL_MAX = CAL_MAX_S * CLK_HZ;
  // ========================================
  // State
  typedef struct packed {
    asc_state_t fsm;
    logic [31:0] ctrl;
    logic [8:0] div;
    logic [23:0] rate;
    logic [3:0] src;
    logic [31:0] cnt;
    logic [31:0] cal_len;
    logic ready;
    logic cal_pass;
    logic ac_restore;
    logic ready_prev;
    logic cal_done_ev;
    logic init_ev;
    logic irq_cond_prev;
    logic ext_clk_prev;
    logic ext_sync_prev;
    logic [31:0] rdata;
    logic [3:0] rd_ch;
  } asc_ctrl_t;
  asc_ctrl_t st_ff;
  asc_ctrl_t nxt_st;
  logic acc;
  logic wr;
  logic ext_edge;
  logic sync_edge;
  logic src_tick;
  logic div_tick;
  logic div_wave;
  logic [31:0] mem_rd;
  logic [2:0] irq_sel;
  logic irq_cond;
  logic sync_go;
  logic cfg_change;
  logic [31:0] seq_len;
  logic fast_mode;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign ext_edge = ext_clk_in && !st_ff.ext_clk_prev;
  assign sync_edge = ext_sync_in && !st_ff.ext_sync_prev;
  // ========================================
  // Clock routing
  always_comb begin
    src_tick = gen_clk_tick;
    if (!st_ff.ctrl[B_CLK_INIT] && st_ff.src == SRC_EXT) begin
      src_tick = ext_edge;
    end
  end
  asc_div u_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .src_tick(src_tick),
    .ratio(st_ff.div),
    .tick(div_tick),
    .wave(div_wave)
  );
  asc_cal_mem u_mem (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_en(cal_corr_valid && st_ff.fsm == ST_CAL),
    .wr_ch(cal_corr_ch),
    .wr_data(cal_corr_data),
    .rd_ch(st_ff.rd_ch),
    .rd_data(mem_rd)
  );
  // Direct mode bypasses the divider entirely
  assign adc_clk_tick = (!st_ff.ctrl[B_CLK_INIT] && st_ff.src == SRC_DIRECT) ? ext_edge : div_tick;
  // Connector roles; enables are low while driving, reset leaves both released
  assign ext_clk_oe_n = !st_ff.ctrl[B_CLK_INIT];
  assign ext_sync_oe_n = !st_ff.ctrl[B_SYNC_INIT];
  assign ext_clk_out = st_ff.ctrl[B_RAW_GEN] ? gen_clk_tick : div_wave;
  assign ext_sync_out = wr && paddr == OFF_CTRL && pwdata[B_SYNC];
  // ========================================
  // Sequencing
  always_comb begin
    // The sequence runs in the mode being written, not the one being left
    fast_mode = (wr && paddr == OFF_CTRL) ? pwdata[B_FAST] : st_ff.ctrl[B_FAST];
    cfg_change = 1'b0;
    if (wr) begin
      unique case (paddr)
        OFF_RATE: cfg_change = pwdata[23:0] != st_ff.rate;
        OFF_SRC: cfg_change = pwdata[3:0] != st_ff.src;
        OFF_DIV: cfg_change = pwdata[8:0] != st_ff.div;
        OFF_CTRL: cfg_change = pwdata[B_FAST] != st_ff.ctrl[B_FAST];
        default: cfg_change = 1'b0;
      endcase
    end
    // Software write, peer pulse or configuration change; each is one pulse, so one sequence
    sync_go = (wr && paddr == OFF_CTRL && pwdata[B_SYNC])
      || (!st_ff.ctrl[B_SYNC_INIT] && st_ff.ctrl[B_EXT_SYNC] && sync_edge)
      || cfg_change;
    // Sample interval length depends on conversion mode
    if (st_ff.ctrl[B_FLUSH] && !cfg_change) begin
      seq_len = fast_mode ? 32'(FLUSH_FAST) : 32'(FLUSH_SLOW);
    end else begin
      seq_len = fast_mode ? 32'(SYNC_FAST) : 32'(SYNC_SLOW);
    end
  end
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_clk_prev = ext_clk_in;
    nxt_st.ext_sync_prev = ext_sync_in;
    nxt_st.cal_done_ev = 1'b0;
    nxt_st.init_ev = 1'b0;
    nxt_st.ready_prev = st_ff.ready;
    nxt_st.ctrl[B_SYNC] = 1'b0;
    if (wr) begin
      unique case (paddr)
        OFF_CTRL: begin
          nxt_st.ctrl = pwdata & 32'h0000_ffff;
          nxt_st.ctrl[B_SYNC] = 1'b0;
          // Flag is cleared by writing zero; a new request in this cycle still wins
          nxt_st.ctrl[B_IRQ_FLAG] = st_ff.ctrl[B_IRQ_FLAG] & pwdata[B_IRQ_FLAG];
          // A request outside idle is dropped so the bit cannot stick high
          nxt_st.ctrl[B_CAL] = st_ff.ctrl[B_CAL] | (pwdata[B_CAL] && st_ff.fsm == ST_IDLE);
        end
        OFF_DIV: nxt_st.div = pwdata[8:0];
        OFF_RATE: nxt_st.rate = pwdata[23:0];
        OFF_SRC: nxt_st.src = pwdata[3:0];
        OFF_CALRES: nxt_st.rd_ch = pwdata[3:0];
        default: nxt_st.rd_ch = st_ff.rd_ch;
      endcase
    end
    unique case (st_ff.fsm)
      ST_IDLE: begin
        if (wr && paddr == OFF_CTRL && pwdata[B_CAL] && !st_ff.ctrl[B_CAL]) begin
          nxt_st.fsm = ST_CAL;
          nxt_st.ready = 1'b0;
          nxt_st.cnt = '0;
          nxt_st.ac_restore = pwdata[B_AC];
          // Rate-dependent term approximated as 16384 system clocks per divisor count
          nxt_st.cal_len = 32'(CAL_BASE) + {st_ff.div, 14'h0000};
          if (nxt_st.cal_len > 32'(CAL_MAX)) begin
            nxt_st.cal_len = 32'(CAL_MAX);
          end
        end else if (sync_go) begin
          nxt_st.fsm = (st_ff.ctrl[B_FLUSH] && !cfg_change) ? ST_FLUSH : ST_SYNC;
          nxt_st.ready = 1'b0;
          nxt_st.cnt = seq_len;
        end
      end
      ST_SYNC, ST_FLUSH: begin
        if (sync_go) begin
          nxt_st.cnt = seq_len;
        end else if (adc_clk_tick) begin
          // No converter clock means the sequence never ends
          if (st_ff.cnt <= 32'h0000_0001) begin
            nxt_st.fsm = ST_IDLE;
            nxt_st.ready = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
          end
        end
      end
      ST_CAL: begin
        nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
        if (st_ff.cnt + 32'h0000_0001 >= st_ff.cal_len) begin
          nxt_st.ctrl[B_CAL] = 1'b0;
          nxt_st.cal_done_ev = 1'b1;
          // Disabled groups count as failed channels
          nxt_st.cal_pass = (&cal_ch_ok) && (&st_ff.ctrl[B_GRP_EN +: 2]);
          nxt_st.cnt = '0;
          nxt_st.fsm = st_ff.ac_restore ? ST_SETTLE : ST_IDLE;
          nxt_st.ready = !st_ff.ac_restore;
        end
      end
      ST_SETTLE: begin
        nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
        if (st_ff.cnt + 32'h0000_0001 >= 32'(AC_SETTLE)) begin
          nxt_st.fsm = ST_IDLE;
          nxt_st.ready = 1'b1;
        end
      end
      default: nxt_st.fsm = ST_IDLE;
    endcase
    // Edge-detected selected condition sets the sticky flag; set beats clear
    if (irq_cond && !st_ff.irq_cond_prev) begin
      nxt_st.ctrl[B_IRQ_FLAG] = 1'b1;
    end
    nxt_st.irq_cond_prev = irq_cond;
    // Register read data
    unique case (paddr)
      OFF_CTRL: nxt_st.rdata = st_ff.ctrl;
      OFF_STAT: nxt_st.rdata = {29'h0000_0000, st_ff.fsm != ST_IDLE, st_ff.cal_pass, st_ff.ready};
      OFF_DIV: nxt_st.rdata = {23'h00_0000, st_ff.div};
      OFF_RATE: nxt_st.rdata = {8'h00, st_ff.rate};
      OFF_SRC: nxt_st.rdata = {28'h000_0000, st_ff.src};
      OFF_CALRES: nxt_st.rdata = mem_rd;
      default: nxt_st.rdata = 32'h0000_0000;
    endcase
  end
  assign irq_sel = st_ff.ctrl[B_IRQ_SEL +: 3];
  always_comb begin
    unique case (irq_sel)
      IRQ_INIT: irq_cond = st_ff.init_ev;
      IRQ_CAL: irq_cond = st_ff.cal_done_ev;
      IRQ_READY: irq_cond = st_ff.ready && !st_ff.ready_prev;
      default: irq_cond = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff.fsm <= ST_IDLE;
      st_ff.ctrl <= RST_CTRL;
      st_ff.div <= RST_DIV;
      st_ff.rate <= RST_RATE;
      st_ff.src <= RST_SRC;
      st_ff.cnt <= '0;
      st_ff.cal_len <= '0;
      st_ff.ready <= 1'b1;
      st_ff.cal_pass <= 1'b0;
      st_ff.ac_restore <= 1'b0;
      st_ff.ready_prev <= 1'b1;
      st_ff.cal_done_ev <= 1'b0;
      st_ff.init_ev <= 1'b1;
      st_ff.irq_cond_prev <= 1'b0;
      st_ff.ext_clk_prev <= 1'b0;
      st_ff.ext_sync_prev <= 1'b0;
      st_ff.rdata <= '0;
      st_ff.rd_ch <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ========================================
  // Outputs
  assign prdata = st_ff.rdata;
  // No wait states; read data is registered from the address of the setup cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign adc_reset = st_ff.fsm == ST_SYNC;
  assign buf_reset = st_ff.fsm == ST_SYNC || st_ff.fsm == ST_FLUSH;
  assign buf_run = st_ff.fsm == ST_IDLE && st_ff.ready;
  // DC forced while calibrating
  assign ac_coupling = st_ff.ctrl[B_AC] && st_ff.fsm != ST_CAL;
  assign host_irq = st_ff.ctrl[B_IRQ_FLAG] && st_ff.ctrl[B_IRQ_EMU];
endmodule

// ---- asc_assertions.sv ----
// Checker: port-level assertions for the sync and autocal control block
`timescale 1ns/10ps
module asc_assertions
  import asc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic gen_clk_tick,
  input wire logic ext_clk_in,
  input wire logic ext_clk_out,
  input wire logic ext_clk_oe_n,
  input wire logic ext_sync_out,
  input wire logic ext_sync_oe_n,
  input wire logic adc_clk_tick,
  input wire logic adc_reset,
  input wire logic buf_reset,
  input wire logic buf_run,
  input wire logic ac_coupling,
  input wire logic host_irq
);
  // ========================================
  // Shadow of written control state
  logic [31:0] ctl_ff;
  logic [3:0] src_ff;
  logic [1:0] age_ff;
  logic wr_ctl;
  logic wr_src;
  assign wr_ctl = psel && penable && pwrite && paddr == OFF_CTRL;
  assign wr_src = psel && penable && pwrite && paddr == OFF_SRC;
  // Age saturates so checks wait out the register pipeline after a write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_ff <= RST_CTRL;
      src_ff <= RST_SRC;
      age_ff <= 2'h3;
    end else begin
      if (wr_ctl) ctl_ff <= pwdata;
      if (wr_src) src_ff <= pwdata[3:0];
      age_ff <= wr_ctl ? 2'h0 : (age_ff == 2'h3 ? age_ff : age_ff + 2'h1);
    end
  end
  // ========================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_clk_pin_dir: assert property (age_ff == 2'h3 |-> ext_clk_oe_n == !ctl_ff[B_CLK_INIT])
    else $error("clock pin direction wrong");
  a_sync_pin_dir: assert property (age_ff == 2'h3 |-> ext_sync_oe_n == !ctl_ff[B_SYNC_INIT])
    else $error("sync pin direction wrong");
  a_raw_clk_out: assert property (age_ff == 2'h3 && ctl_ff[B_CLK_INIT] && ctl_ff[B_RAW_GEN]
    |-> ext_clk_out == gen_clk_tick) else $error("raw clock output wrong");
  a_sync_pulse_out: assert property (wr_ctl && pwdata[B_SYNC] |-> ext_sync_out)
    else $error("no sync pulse on request");
  a_irq_gate: assert property (age_ff == 2'h3 && !ctl_ff[B_IRQ_EMU] |-> !host_irq)
    else $error("host irq without emulation");
  a_sync_start: assert property (wr_ctl && pwdata[B_SYNC] |-> ##[1:3] (buf_reset && !buf_run))
    else $error("sync request did not start");
  a_fast_toggle: assert property (wr_ctl && pwdata[B_FAST] != ctl_ff[B_FAST]
    |-> ##[1:3] (buf_reset && !buf_run)) else $error("fast toggle missed reset");
  a_sync_bufs: assert property (adc_reset |-> buf_reset && !buf_run)
    else $error("buffers live during sync");
  a_bufs_start: assert property ($fell(buf_reset) |-> buf_run)
    else $error("buffers not restarted after sequence");
  a_ac_forced: assert property (age_ff == 2'h3 && !ctl_ff[B_AC] |-> !ac_coupling)
    else $error("ac coupling not selected");
  a_direct_tick: assert property (src_ff == SRC_DIRECT && !ctl_ff[B_CLK_INIT]
    && $rose(ext_clk_in) |-> ##[0:4] adc_clk_tick) else $error("direct clock edge lost");
endmodule
bind asc_ctrl asc_assertions u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .gen_clk_tick(gen_clk_tick), .ext_clk_in(ext_clk_in),
  .ext_clk_out(ext_clk_out), .ext_clk_oe_n(ext_clk_oe_n), .ext_sync_out(ext_sync_out),
  .ext_sync_oe_n(ext_sync_oe_n), .adc_clk_tick(adc_clk_tick), .adc_reset(adc_reset),
  .buf_reset(buf_reset), .buf_run(buf_run), .ac_coupling(ac_coupling), .host_irq(host_irq)
);

// ---- asc_peer.sv ----
// Peer board model: external clock and sync source
`timescale 1ns/10ps
module asc_peer (
  input wire logic clk_sys,
  input wire logic run_clk,
  input wire logic fire_sync,
  output logic peer_clk,
  output logic peer_sync
);
  logic [1:0] div_ff;
  initial begin
    div_ff = 2'h0;
    peer_clk = 1'b0;
    peer_sync = 1'b0;
  end
  // Clock stands still low outside runs, so no stale edge leaks in
  always @(posedge clk_sys) begin
    div_ff <= run_clk ? div_ff + 2'h1 : 2'h0;
    if (!run_clk) peer_clk <= 1'b0;
    else if (div_ff == 2'h3) peer_clk <= !peer_clk;
    peer_sync <= fire_sync;
  end
endmodule

// ---- asc_ctrl_tb.sv ----
// Testbench: APB-driven scenarios for the sync and autocal control block
`timescale 1ns/10ps
module asc_ctrl_tb;
  import asc_pkg::*;
  localparam logic [31:0] BASE = RST_CTRL | (32'h1 << B_FAST);
  logic clk_sys, sys_rst, psel, penable, pwrite, gen_clk_tick, cal_corr_valid;
  logic pready, pslverr, ext_clk_in, ext_clk_out, ext_clk_oe_n, ext_sync_in;
  logic ext_sync_out, ext_sync_oe_n, adc_clk_tick, adc_reset, buf_reset, buf_run;
  logic ac_coupling, host_irq, run_clk, fire_sync, peer_clk, peer_sync, prev;
  logic [3:0] cal_corr_ch;
  logic [7:0] paddr;
  logic [11:0] cal_ch_ok;
  logic [31:0] pwdata, prdata, cal_corr_data, q;
  int fail_count, checks, n, d1, d2, ne, nt;
  // Board owns the wire only while its enable is low
  assign ext_clk_in = ext_clk_oe_n ? peer_clk : ext_clk_out;
  assign ext_sync_in = ext_sync_oe_n ? peer_sync : ext_sync_out;
  always #20 clk_sys = !clk_sys;
  asc_ctrl #(.CAL_BASE(50), .AC_SETTLE(20)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gen_clk_tick(gen_clk_tick), .ext_clk_in(ext_clk_in), .ext_clk_out(ext_clk_out),
    .ext_clk_oe_n(ext_clk_oe_n), .ext_sync_in(ext_sync_in), .ext_sync_out(ext_sync_out),
    .ext_sync_oe_n(ext_sync_oe_n), .adc_clk_tick(adc_clk_tick), .adc_reset(adc_reset),
    .buf_reset(buf_reset), .buf_run(buf_run), .ac_coupling(ac_coupling),
    .cal_ch_ok(cal_ch_ok), .cal_corr_valid(cal_corr_valid), .cal_corr_ch(cal_corr_ch),
    .cal_corr_data(cal_corr_data), .host_irq(host_irq)
  );
  asc_peer peer (.clk_sys(clk_sys), .run_clk(run_clk), .fire_sync(fire_sync),
    .peer_clk(peer_clk), .peer_sync(peer_sync));
  // ========================================
  // Helpers
  function automatic logic [31:0] bt(input int b);
    return 32'h1 << b;
  endfunction
  function automatic logic [31:0] sel(input logic [2:0] s);
    return {29'h0, s} << B_IRQ_SEL;
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return buf_run;
      1: return host_irq;
      default: return buf_reset;
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Called just after a rising edge; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    if (k >= 20) begin
      chk(32'h0, 32'h1, "pready timeout");
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(q, exp, m);
  endtask
  // Bounded wait for a level; a timeout ends the run
  task automatic wait_on(input int w, input int lim, output int c);
    c = 0;
    while (sig(w) !== 1'b1 && c < lim) begin
      @(posedge clk_sys);
      c++;
    end
    if (c >= lim) begin
      chk(32'h0, 32'h1, "wait timeout");
      complete_run();
    end
  endtask
  task automatic reset_chk();
    chk({30'h0, ext_clk_oe_n, ext_sync_oe_n}, 32'h3, "pins released");
    chk({31'h0, host_irq}, 32'h0, "irq idle");
    rd(OFF_DIV, {23'h0, RST_DIV}, "div reset");
    rd(OFF_RATE, {8'h0, RST_RATE}, "rate reset");
    rd(OFF_SRC, {28'h0, RST_SRC}, "src reset");
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0, "unmapped");
    rd(OFF_CTRL, RST_CTRL | bt(B_IRQ_FLAG), "ctrl reset");
  endtask
  // ========================================
  // Scenarios
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, cal_corr_valid, run_clk, fire_sync} = 6'h0;
    gen_clk_tick = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    cal_ch_ok = 12'hfff;
    cal_corr_ch = 4'h0;
    cal_corr_data = 32'h0;
    fail_count = 0;
    checks = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    reset_chk();
    $display("test reset done");
    wr(OFF_DIV, 32'h1);
    chk({31'h0, adc_reset}, 32'h1, "auto sync");
    wr(OFF_CTRL, BASE | sel(IRQ_READY));
    rd(OFF_STAT, bt(S_BUSY), "ready low");
    wait_on(0, 80000, n);
    rd(OFF_CTRL, BASE | sel(IRQ_READY) | bt(B_IRQ_FLAG), "ready event");
    chk({31'h0, host_irq}, 32'h0, "irq gated");
    wr(OFF_CTRL, BASE | sel(IRQ_READY) | bt(B_IRQ_FLAG) | bt(B_IRQ_EMU));
    chk({31'h0, host_irq}, 32'h1, "irq out");
    $display("test sync done");
    wr(OFF_CTRL, BASE | bt(B_FLUSH) | bt(B_CLK_INIT) | bt(B_SYNC_INIT) | bt(B_RAW_GEN));
    chk({30'h0, ext_clk_oe_n, ext_sync_oe_n}, 32'h0, "initiator pins");
    wr(OFF_CTRL, BASE | bt(B_FLUSH) | bt(B_CLK_INIT) | bt(B_SYNC_INIT) | bt(B_SYNC));
    chk({30'h0, adc_reset, buf_reset}, 32'h1, "flush only");
    wait_on(0, 5000, d1);
    wr(OFF_CTRL, BASE | bt(B_FLUSH) | bt(B_SYNC_INIT) | bt(B_SYNC));
    repeat (d1 / 2) @(posedge clk_sys);
    wr(OFF_CTRL, BASE | bt(B_FLUSH) | bt(B_SYNC_INIT) | bt(B_SYNC));
    wait_on(0, 5000, d2);
    chk({31'h0, d2 + 4 > d1}, 32'h1, "restart");
    wr(OFF_CTRL, BASE | bt(B_FLUSH) | bt(B_EXT_SYNC));
    fire_sync <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fire_sync <= 1'b0;
    wait_on(2, 20, n);
    wait_on(0, 5000, n);
    $display("test flush done");
    wr(OFF_CTRL, BASE | bt(B_AC) | sel(IRQ_CAL) | bt(B_IRQ_EMU));
    wait_on(0, 200, n);
    wr(OFF_CTRL, BASE | bt(B_AC) | sel(IRQ_CAL) | bt(B_IRQ_EMU) | bt(B_CAL));
    chk({31'h0, ac_coupling}, 32'h0, "dc forced");
    cal_corr_ch <= 4'h3;
    cal_corr_data <= 32'h1234_abcd;
    cal_corr_valid <= 1'b1;
    @(posedge clk_sys);
    cal_corr_valid <= 1'b0;
    wait_on(1, 40000, n);
    chk({31'h0, n >= 50}, 32'h1, "cal length");
    chk({30'h0, ac_coupling, buf_run}, 32'h2, "ac settle");
    rd(OFF_STAT, bt(S_CAL_PASS) | bt(S_BUSY), "cal pass");
    rd(OFF_CTRL, BASE | bt(B_AC) | sel(IRQ_CAL) | bt(B_IRQ_EMU) | bt(B_IRQ_FLAG), "cal clr");
    wr(OFF_CALRES, 32'h3);
    rd(OFF_CALRES, 32'h1234_abcd, "corr kept");
    cal_ch_ok <= 12'h7ff;
    wait_on(0, 200, n);
    wr(OFF_CTRL, BASE | sel(IRQ_CAL) | bt(B_IRQ_EMU));
    wr(OFF_CTRL, BASE | sel(IRQ_CAL) | bt(B_IRQ_EMU) | bt(B_CAL));
    wait_on(1, 40000, n);
    rd(OFF_STAT, bt(S_READY), "cal fail");
    $display("test cal done");
    run_clk <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(OFF_SRC, {28'h0, m == 0 ? SRC_DIRECT : SRC_EXT});
      wr(OFF_CTRL, BASE | bt(B_SYNC));
      chk({31'h0, adc_reset}, 32'h1, "resync");
      {ne, nt, prev} = 0;
      repeat (400) begin
        @(posedge clk_sys);
        ne += (ext_clk_in && !prev) ? 1 : 0;
        nt += adc_clk_tick ? 1 : 0;
        prev = ext_clk_in;
      end
      chk({31'h0, ne - nt <= 1 && nt - ne <= 1 && ne > 10}, 32'h1, "clock ticks");
    end
    run_clk <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    reset_chk();
    $display("test direct done");
    complete_run();
  end
endmodule
